// File: ebp_pkg.sv
package ebp_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_TIM0     = 8'h08;
  localparam logic [7:0]  ADDR_TIM1     = 8'h0C;
  localparam int          NUM_CS        = 2;
  // ==========================================================================
  // control fields
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_CS       = 1;
  localparam int          CTRL_WRITE    = 2;
  localparam int          CTRL_CLK_SYS  = 8;
  localparam int          CTRL_CLK_HS   = 9;
  // ==========================================================================
  // timing register fields
  localparam int          TIM_AB        = 0;
  localparam int          TIM_C_LO      = 1;
  localparam int          TIM_D         = 3;
  localparam int          TIM_E_LO      = 4;
  localparam int          TIM_F_LO      = 9;
  localparam int          TIM_RDY_EN    = 11;
  localparam int          TIM_WIN_LO    = 12;
  localparam int          TIM_W         = 14;
  localparam logic [13:0] TIM_RESET     = 14'h0000;
  // ==========================================================================
  // status fields
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_PHASE_LO = 1;
  localparam int          STAT_LAST_CS  = 4;
  // ==========================================================================
  // phases
  typedef enum logic [2:0] {
    EBP_IDLE, EBP_AB, EBP_C, EBP_D, EBP_E, EBP_F
  } ebp_phase_e;
endpackage : ebp_pkg

// File: ebp_top.sv
`timescale 1ns/1ps
module ebp_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_ready,
  output logic      [1:0]  bus_cs_n,
  output logic             bus_write,
  output logic      [2:0]  bus_phase,
  output logic             ext_clk_sel_sys,
  output logic             ext_clk_hs_en
);
  // ==========================================================================
  // state
  logic [13:0]        tim [ebp_pkg::NUM_CS];
  logic [13:0]        next_tim [ebp_pkg::NUM_CS];
  logic [13:0]        cur_tim, next_cur_tim;
  logic [2:0]         cur_ab, next_cur_ab;
  ebp_pkg::ebp_phase_e state, next_state;
  logic [4:0]         cnt, next_cnt;
  logic [5:0]         ph_cyc, next_ph_cyc;
  logic               last_cs, next_last_cs;
  logic               cs_q, next_cs_q;
  logic               next_bus_write;
  logic [1:0]         next_bus_cs_n;
  logic               next_clk_sys, next_clk_hs;
  logic [31:0]        next_prdata;
  logic               next_pready, next_pslverr;
  logic               ready_meta, ready_sync;
  logic               acc, hit;

  // ==========================================================================
  // next values
  always_comb begin
    acc           = psel && penable && pready;
    hit           = 1'b1;
    next_tim      = tim;
    next_cur_tim  = cur_tim;
    next_cur_ab   = cur_ab;
    next_state    = state;
    next_cnt      = cnt;
    next_last_cs  = last_cs;
    next_cs_q     = cs_q;
    next_bus_write = bus_write;
    next_clk_sys  = ext_clk_sel_sys;
    next_clk_hs   = ext_clk_hs_en;
    next_prdata   = prdata;
    next_pready   = psel && penable && !pready;
    next_pslverr  = 1'b0;
    unique case (paddr)
      ebp_pkg::ADDR_CTRL, ebp_pkg::ADDR_STATUS,
      ebp_pkg::ADDR_TIM0, ebp_pkg::ADDR_TIM1: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    if (psel && penable && !pready) begin
      next_pslverr = !hit;
      unique case (paddr)
        ebp_pkg::ADDR_CTRL: next_prdata = {22'h000000, ext_clk_hs_en, ext_clk_sel_sys,
                                           5'h00, bus_write, cs_q, 1'b0};
        ebp_pkg::ADDR_STATUS: next_prdata = {27'h0000000, last_cs, 3'(state),
                                             state != ebp_pkg::EBP_IDLE};
        ebp_pkg::ADDR_TIM0: next_prdata = {18'h00000, tim[0]};
        ebp_pkg::ADDR_TIM1: next_prdata = {18'h00000, tim[1]};
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (acc && pwrite) begin
      unique case (paddr)
        ebp_pkg::ADDR_TIM0: next_tim[0] = pwdata[13:0];
        ebp_pkg::ADDR_TIM1: next_tim[1] = pwdata[13:0];
        ebp_pkg::ADDR_CTRL: begin
          next_clk_sys = pwdata[ebp_pkg::CTRL_CLK_SYS];
          next_clk_hs  = pwdata[ebp_pkg::CTRL_CLK_HS];
        end
        default: ;
      endcase
    end
    // phase sequencer, one count per system clock
    unique case (state)
      ebp_pkg::EBP_IDLE: begin
        if (acc && pwrite && paddr == ebp_pkg::ADDR_CTRL && pwdata[ebp_pkg::CTRL_START]) begin
          next_cs_q      = pwdata[ebp_pkg::CTRL_CS];
          next_bus_write = pwdata[ebp_pkg::CTRL_WRITE];
          next_cur_tim   = tim[pwdata[ebp_pkg::CTRL_CS]];
          next_cur_ab    = 3'(tim[pwdata[ebp_pkg::CTRL_CS]][ebp_pkg::TIM_AB]) + 3'h1;
          if (pwdata[ebp_pkg::CTRL_CS] != last_cs)
            next_cur_ab = next_cur_ab
                        + {1'b0, tim[pwdata[ebp_pkg::CTRL_CS]][ebp_pkg::TIM_WIN_LO +: 2]};
          next_last_cs   = pwdata[ebp_pkg::CTRL_CS];
          next_cnt       = 5'(next_cur_ab - 3'h1);
          next_state     = ebp_pkg::EBP_AB;
        end
      end
      ebp_pkg::EBP_AB, ebp_pkg::EBP_C, ebp_pkg::EBP_D, ebp_pkg::EBP_F: begin
        if (cnt != 5'h00) begin
          next_cnt = cnt - 5'h01;
        end else if (state == ebp_pkg::EBP_F) begin
          next_state = ebp_pkg::EBP_IDLE;
        end else if (state == ebp_pkg::EBP_AB && cur_tim[ebp_pkg::TIM_C_LO +: 2] != 2'h0) begin
          next_state = ebp_pkg::EBP_C;
          next_cnt   = 5'(cur_tim[ebp_pkg::TIM_C_LO +: 2] - 2'h1);
        end else if (state != ebp_pkg::EBP_D && cur_tim[ebp_pkg::TIM_D]) begin
          next_state = ebp_pkg::EBP_D;
          next_cnt   = 5'h00;
        end else begin
          next_state = ebp_pkg::EBP_E;
          next_cnt   = cur_tim[ebp_pkg::TIM_E_LO +: 5];
        end
      end
      ebp_pkg::EBP_E: begin
        if (cnt != 5'h00) begin
          next_cnt = cnt - 5'h01;
        end else if (!cur_tim[ebp_pkg::TIM_RDY_EN] || ready_sync) begin
          if (cur_tim[ebp_pkg::TIM_F_LO +: 2] != 2'h0) begin
            next_state = ebp_pkg::EBP_F;
            next_cnt   = 5'(cur_tim[ebp_pkg::TIM_F_LO +: 2] - 2'h1);
          end else begin
            next_state = ebp_pkg::EBP_IDLE;
          end
        end
      end
      default: next_state = ebp_pkg::EBP_IDLE;
    endcase
    next_bus_cs_n = 2'h3;
    if (next_state != ebp_pkg::EBP_IDLE)
      next_bus_cs_n[next_cs_q] = 1'b0;
    next_ph_cyc = (next_state != state) ? 6'h00 : ph_cyc + 6'h01;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ebp_pkg::NUM_CS; i++) begin
        tim[i] <= ebp_pkg::TIM_RESET;
      end
      cur_tim         <= ebp_pkg::TIM_RESET;
      cur_ab          <= 3'h1;
      state           <= ebp_pkg::EBP_IDLE;
      cnt             <= 5'h00;
      ph_cyc          <= 6'h00;
      last_cs         <= 1'b0;
      cs_q            <= 1'b0;
      bus_write       <= 1'b0;
      bus_cs_n        <= 2'h3;
      bus_phase       <= 3'h0;
      ext_clk_sel_sys <= 1'b0;
      ext_clk_hs_en   <= 1'b0;
      prdata          <= 32'h00000000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      ready_meta      <= 1'b0;
      ready_sync      <= 1'b0;
    end else begin
      tim             <= next_tim;
      cur_tim         <= next_cur_tim;
      cur_ab          <= next_cur_ab;
      state           <= next_state;
      cnt             <= next_cnt;
      ph_cyc          <= next_ph_cyc;
      last_cs         <= next_last_cs;
      cs_q            <= next_cs_q;
      bus_write       <= next_bus_write;
      bus_cs_n        <= next_bus_cs_n;
      bus_phase       <= 3'(next_state);
      ext_clk_sel_sys <= next_clk_sys;
      ext_clk_hs_en   <= next_clk_hs;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
      ready_meta      <= ext_ready;
      ready_sync      <= ready_meta;
    end
  end

  // ==========================================================================
  // checks
  sequence leave_s(ebp_pkg::ebp_phase_e p);
    state == p && next_state != p;
  endsequence

  phase_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ebp_pkg::EBP_E |=> state inside {ebp_pkg::EBP_E, ebp_pkg::EBP_F, ebp_pkg::EBP_IDLE})
    else $error("bad phase after access");
  ab_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    leave_s(ebp_pkg::EBP_AB) |-> ph_cyc + 6'h01 == 6'(cur_ab))
    else $error("address setup length wrong");
  cmd_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    leave_s(ebp_pkg::EBP_C) |-> ph_cyc + 6'h01 == 6'(cur_tim[ebp_pkg::TIM_C_LO +: 2]))
    else $error("command delay length wrong");
  wd_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == ebp_pkg::EBP_D) |=> state == ebp_pkg::EBP_E)
    else $error("data setup not one cycle");
  access_min_a: assert property (@(posedge pclk) disable iff (!presetn)
    leave_s(ebp_pkg::EBP_E) |-> ph_cyc >= 6'(cur_tim[ebp_pkg::TIM_E_LO +: 5]))
    else $error("access too short");
  ready_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ebp_pkg::EBP_E && !cur_tim[ebp_pkg::TIM_RDY_EN]
      && ph_cyc == 6'(cur_tim[ebp_pkg::TIM_E_LO +: 5]) |=> state != ebp_pkg::EBP_E)
    else $error("access overran count");
  hold_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    leave_s(ebp_pkg::EBP_F) |-> ph_cyc + 6'h01 == 6'(cur_tim[ebp_pkg::TIM_F_LO +: 2]))
    else $error("hold length wrong");
  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    state != ebp_pkg::EBP_IDLE && cnt != 5'h00 |=> cnt == $past(cnt) - 5'h01)
    else $error("counter skipped");
  clk_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && paddr == ebp_pkg::ADDR_CTRL |=>
      ext_clk_sel_sys == $past(pwdata[ebp_pkg::CTRL_CLK_SYS])
      && ext_clk_hs_en == $past(pwdata[ebp_pkg::CTRL_CLK_HS]))
    else $error("clock pin select not taken");
endmodule : ebp_top

// File: ebp_ext_bus_model.sv
`timescale 1ns/1ps
module ebp_ext_bus_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] bus_cs_n,
  input  wire logic [2:0] bus_phase,
  input  wire logic [2:0] wait_len,
  input  wire logic       noise,
  output logic            ext_ready
);
  logic [2:0] cnt;
  // ==========================================================================
  // ready answer, prompt or slow; toggles when released and noisy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 3'h0;
      ext_ready <= 1'b0;
    end else if (bus_phase == ebp_pkg::EBP_E && bus_cs_n != 2'b11) begin
      if (cnt != wait_len) cnt <= cnt + 3'h1;
      ext_ready <= (cnt == wait_len);
    end else begin
      cnt       <= 3'h0;
      ext_ready <= noise ? ~ext_ready : 1'b0;
    end
  end
endmodule : ebp_ext_bus_model

// File: tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, noise = 0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  wait_len = 3'h0, bus_phase, cur = 3'h0;
  logic [1:0]  bus_cs_n;
  logic        pready, pslverr, ext_ready, bus_write, ext_clk_sel_sys, ext_clk_hs_en;
  logic [5:0]  run = 6'h0;
  logic [32:0] rq[$];
  logic [9:0]  pq[$];
  logic [13:0] tt;
  logic [13:0] edge_t[3] = '{14'h0000, 14'h37FF, 14'h3FFF};
  int          n_errors = 0, cmp_count = 0, last_cs = 0, cs;
  always #12.5 pclk = ~pclk;
  ebp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_ready(ext_ready), .bus_cs_n(bus_cs_n), .bus_write(bus_write),
    .bus_phase(bus_phase), .ext_clk_sel_sys(ext_clk_sel_sys), .ext_clk_hs_en(ext_clk_hs_en));
  ebp_ext_bus_model ext (.pclk(pclk), .presetn(presetn), .bus_cs_n(bus_cs_n),
    .bus_phase(bus_phase), .wait_len(wait_len), .noise(noise), .ext_ready(ext_ready));
  // ==========================================================================
  // monitors: oldest note against each result
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      `CHK({pslverr, pwrite ? 32'h0 : prdata}, rq.size() ? rq.pop_front() : 33'h0)
    end
    if (bus_phase !== cur) begin
      if (cur != 3'h0) chk_run({cur, run});
      cur <= bus_phase;
      run <= 6'h1;
    end else run <= run + 6'h1;
  end
  task automatic chk_run(input logic [8:0] g);
    logic [9:0] e;
    e = pq.size() ? pq.pop_front() : 10'h3FF;
    if (e[9]) begin
      `CHK(g[8:6], e[8:6])
      `CHK(g[5:0] >= e[5:0], 1'b1)
      `CHK(g[5:0], e[5:0])
    end else `CHK(g, e[8:0])
  endtask : chk_run
  // ==========================================================================
  // apb master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    rq.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic bus_cycle(input int c, input logic wr, input logic [13:0] t);
    int ab;
    logic [5:0] el;
    ab = (t[0] ? 2 : 1) + ((c != last_cs) ? int'(t[13:12]) : 0);
    // access with ready: model answers wait_len plus one edges into the access, two flops of sync, then one edge
    el = 6'(t[8:4]) + 6'h01;
    if (t[11] && el < 6'(wait_len) + 6'h04) el = 6'(wait_len) + 6'h04;
    apb(1'b1, ebp_pkg::ADDR_TIM0 + 8'(4 * c), 32'(t), 33'h0);
    apb(1'b0, ebp_pkg::ADDR_TIM0 + 8'(4 * c), 32'h0, {19'h0, t});
    pq.push_back({4'h1, 6'(ab)});
    if (t[2:1] != 2'h0) pq.push_back({4'h2, 4'h0, t[2:1]});
    if (t[3]) pq.push_back({4'h3, 6'h1});
    pq.push_back({t[11], 3'h4, el});
    if (t[10:9] != 2'h0) pq.push_back({4'h5, 4'h0, t[10:9]});
    apb(1'b1, ebp_pkg::ADDR_CTRL, {29'h0, wr, c[0], 1'b1}, 33'h0);
    `CHK(bus_cs_n, ~(2'b01 << c))
    `CHK(bus_write, wr)
    if (t[8:4] > 5'd8) apb(1'b1, ebp_pkg::ADDR_CTRL, {29'h0, wr, c[0], 1'b1}, 33'h0);
    while (bus_phase !== 3'h0) @(posedge pclk);
    last_cs = c;
  endtask : bus_cycle
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    close_out();
  end
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h82B5));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) apb(1'b0, 8'(a), 32'h0, 33'h0);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'hFC, 32'hFFFF_FFFF, {1'b1, 32'h0});
    apb(1'b1, ebp_pkg::ADDR_CTRL, 32'h0000_0300, 33'h0);
    `CHK({ext_clk_sel_sys, ext_clk_hs_en}, 2'b11)
    apb(1'b0, ebp_pkg::ADDR_CTRL, 32'h0, {1'b0, 32'h0000_0300});
    apb(1'b1, ebp_pkg::ADDR_CTRL, 32'h0000_0100, 33'h0);
    `CHK({ext_clk_sel_sys, ext_clk_hs_en}, 2'b10)
    for (int i = 0; i < 3; i++) bus_cycle(1 - last_cs, 1'(i), edge_t[i]);
    for (int i = 0; i < 24; i++) begin
      cs       = $urandom % 2;
      tt       = 14'($urandom);
      wait_len <= 3'($urandom);
      noise    <= (i < 12);
      if (i < 12) tt[11] = 1'b0;
      bus_cycle(cs, 1'($urandom), tt);
    end
    repeat (4) @(posedge pclk);
    `CHK(pq.size(), 0)
    close_out();
  end
endmodule : tb
